// ===== include/mps_regs.vh
// Register map, field positions and timing constants of the print sequencer
`ifndef MPS_REGS_VH
`define MPS_REGS_VH
// ********************
// Register offsets
// ********************
`define MPS_CTRL_OFF 12'h000
`define MPS_INTV_OFF 12'h004
`define MPS_STAT_OFF 12'h008
`define MPS_COUNT_OFF 12'h00C
`define MPS_ELAP_OFF 12'h010
`define MPS_MEAS_OFF 12'h014
`define MPS_CMP_OFF 12'h018
`define MPS_STATS_OFF 12'h01C
`define MPS_ID_OFF 12'h020
// ********************
// Fields and reset values
// ********************
`define MPS_CTRL_MEASDISP 0
`define MPS_CTRL_STATDISP 1
`define MPS_CTRL_STATEN 2
`define MPS_CTRL_INTTRIG 3
`define MPS_CTRL_RESET 32'h0000_0000
`define MPS_INTV_RESET 12'h000
`define MPS_INTV_MAX 12'hE10
`define MPS_COUNT_MAX 15'h7530
// ********************
// Timing
// ********************
`define MPS_CLK_HZ 10000000
`define MPS_BAUD 9600
`define MPS_BIT_CYCLES (`MPS_CLK_HZ / `MPS_BAUD)
`define MPS_SEC_CYCLES `MPS_CLK_HZ
`define MPS_LINE_CHARS 45
`endif

// ===== verilog/mps_uart_tx.v
// Serial transmitter, 8N1, no flow control
module mps_uart_tx #(
    parameter BIT_CYCLES = 1041
) (
    input wire sys_clk,
    input wire rst,
    input wire txValid,
    input wire [7:0] txData,
    output wire txReady,
    output reg txLine
);
    reg [9:0] shift;
    reg [3:0] bitsLeft;
    reg [15:0] baudCnt;
    assign txReady = (bitsLeft == 4'h0);
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift <= 10'h3FF;
            bitsLeft <= 4'h0;
            baudCnt <= 16'h0000;
            txLine <= 1'b1;
        end else if (bitsLeft == 4'h0) begin
            txLine <= 1'b1;
            if (txValid) begin
                // Stop, data LSB first, start
                shift <= {1'b1, txData, 1'b0};
                bitsLeft <= 4'hA;
                baudCnt <= 16'h0000;
            end
        end else begin
            txLine <= shift[0];
            if (baudCnt == BIT_CYCLES[15:0] - 16'h0001) begin
                baudCnt <= 16'h0000;
                shift <= {1'b1, shift[9:1]};
                bitsLeft <= bitsLeft - 4'h1;
            end else begin
                baudCnt <= baudCnt + 16'h0001;
            end
        end
    end
endmodule // mps_uart_tx

// ===== verilog/mps_print_seq.v
// Print sequencer: request handling, counters and line formatter
`include "mps_regs.vh"
module mps_print_seq #(
    parameter SEC_CYCLES = `MPS_SEC_CYCLES,
    parameter BIT_CYCLES = `MPS_BIT_CYCLES,
    parameter [31:0] ID_CODE = 32'h00A5_0001
) (
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire printKey,
    input wire triggerKey,
    input wire printPin_n,
    input wire triggerInput_n,
    output wire statsSampleAdd,
    output wire txd
);
    // ********************
    // Pin synchronisers
    // ********************
    // ID_CODE default is arbitrary
    reg [1:0] prS1;
    reg [1:0] prS2;
    reg [1:0] prOld;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prS1 <= 2'h3;
            prS2 <= 2'h3;
            prOld <= 2'h3;
        end else begin
            prS1 <= {triggerInput_n, printPin_n};
            prS2 <= prS1;
            prOld <= prS2;
        end
    end
    // Pulled to isolated_common means low
    wire pinPrint = prOld[0] & ~prS2[0];
    wire pinTrig = prOld[1] & ~prS2[1];
    // ********************
    // Registers
    // ********************
    reg [3:0] ctrl;
    reg [11:0] intv;
    reg [31:0] measVal;
    reg [1:0] cmpDec;
    reg [15:0] validCnt;
    reg [31:0] statVal;
    reg runOn;
    reg [14:0] sampleCnt;
    reg [6:0] hrs;
    reg [5:0] mins;
    reg [5:0] secs;
    reg busy;
    wire measDisp = ctrl[`MPS_CTRL_MEASDISP];
    wire statDisp = ctrl[`MPS_CTRL_STATDISP];
    wire apbWr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl <= 4'h0;
            intv <= `MPS_INTV_RESET;
            measVal <= 32'h0000_0000;
            cmpDec <= 2'h0;
            validCnt <= 16'h0000;
            statVal <= 32'h0000_0000;
        end else if (apbWr) begin
            case (paddr)
                `MPS_CTRL_OFF: ctrl <= pwdata[3:0];
                `MPS_INTV_OFF: begin
                    if (pwdata[11:0] <= `MPS_INTV_MAX) begin
                        intv <= pwdata[11:0];
                    end
                end
                `MPS_MEAS_OFF: measVal <= pwdata;
                `MPS_CMP_OFF: cmpDec <= pwdata[1:0];
                `MPS_STATS_OFF: begin
                    validCnt <= pwdata[15:0];
                    statVal <= {16'h0000, pwdata[31:16]};
                end
                default: ctrl <= ctrl;
            endcase
        end
    end
    always @* begin
        case (paddr)
            `MPS_CTRL_OFF: prdata = {28'h0000000, ctrl};
            `MPS_INTV_OFF: prdata = {20'h00000, intv};
            `MPS_STAT_OFF: prdata = {30'h00000000, runOn, busy};
            `MPS_COUNT_OFF: prdata = {17'h00000, sampleCnt};
            `MPS_ELAP_OFF: prdata = {13'h0000, hrs, mins, secs};
            `MPS_MEAS_OFF: prdata = measVal;
            `MPS_CMP_OFF: prdata = {30'h00000000, cmpDec};
            `MPS_STATS_OFF: prdata = {statVal[15:0], validCnt};
            `MPS_ID_OFF: prdata = ID_CODE;
            default: prdata = 32'h0000_0000;
        endcase
    end
    // ********************
    // Requests and interval run
    // ********************
    wire printReq = printKey | pinPrint;
    wire trigReq = (triggerKey | pinTrig) & ctrl[`MPS_CTRL_STATEN]
        & ctrl[`MPS_CTRL_INTTRIG] & measDisp;
    assign statsSampleAdd = trigReq;
    reg [31:0] secCnt;
    reg [11:0] periodCnt;
    wire secTick = runOn & (secCnt == SEC_CYCLES - 1);
    wire periodDue = secTick & (periodCnt == intv - 12'h001);
    // Kinds: 1 value, 2 interval, 3 stats
    reg [1:0] pendKind;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            runOn <= 1'b0;
            secCnt <= 32'h0000_0000;
            periodCnt <= 12'h000;
            hrs <= 7'h00;
            mins <= 6'h00;
            secs <= 6'h00;
            pendKind <= 2'h0;
            sampleCnt <= 15'h0000;
        end else begin
            if (!measDisp || intv == 12'h000) begin
                runOn <= 1'b0;
            end else if (printReq) begin
                runOn <= ~runOn;
                secCnt <= 32'h0000_0000;
                periodCnt <= 12'h000;
                hrs <= 7'h00;
                mins <= 6'h00;
                secs <= 6'h00;
            end else if (secTick) begin
                secCnt <= 32'h0000_0000;
                periodCnt <= periodDue ? 12'h000 : periodCnt + 12'h001;
                if (secs != 6'h3B) begin
                    secs <= secs + 6'h01;
                end else begin
                    secs <= 6'h00;
                    if (mins != 6'h3B) begin
                        mins <= mins + 6'h01;
                    end else begin
                        mins <= 6'h00;
                        hrs <= (hrs == 7'h63) ? 7'h00 : hrs + 7'h01;
                    end
                end
            end else if (runOn) begin
                secCnt <= secCnt + 32'h0000_0001;
            end
            if (busy) begin
                pendKind <= 2'h0;
            end else if (measDisp && printReq && intv == 12'h000) begin
                pendKind <= 2'h1;
            end else if (trigReq) begin
                pendKind <= 2'h1;
            end else if (statDisp && printReq) begin
                pendKind <= 2'h3;
            end else if (periodDue) begin
                pendKind <= 2'h2;
            end
            if (pendKind == 2'h1 && !busy) begin
                sampleCnt <= (sampleCnt == `MPS_COUNT_MAX) ? 15'h0001
                    : sampleCnt + 15'h0001;
            end
        end
    end
    // ********************
    // Line formatter
    // ********************
    // Lines are 6 to 19 characters, always within 45
    function [7:0] hexCh;
        input [3:0] n;
        begin
            hexCh = (n < 4'hA) ? {4'h3, n} : 8'h37 + {4'h0, n};
        end
    endfunction
    function [7:0] decCh;
        input [6:0] n;
        input hi;
        begin
            decCh = 8'h30 + {1'b0, (hi ? n / 7'h0A : n % 7'h0A)};
        end
    endfunction
    reg [4:0] chIdx;
    reg [4:0] chLast;
    reg [1:0] kind;
    reg [7:0] ch;
    wire txReady;
    reg txValid;
    localparam ST_IDLE = 2'b01;
    localparam ST_SEND = 2'b10;
    reg [1:0] state;
    // Widened so the top hex digit reads a defined bit
    wire [15:0] countWide = {1'b0, sampleCnt};
    always @* begin
        ch = 8'h20;
        if (chIdx == chLast - 5'h01) begin
            ch = 8'h0D;
        end else if (chIdx == chLast) begin
            ch = 8'h0A;
        end else if (kind == 2'h3) begin
            // Stats line: count, then value only beyond one sample
            if (chIdx < 5'h04) begin
                ch = hexCh(validCnt[15 - 4 * chIdx[1:0] -: 4]);
            end else if (chIdx > 5'h04 && chIdx < 5'h0D) begin
                ch = hexCh(statVal[31 - 4 * (chIdx - 5'h05) -: 4]);
            end
        end else if (kind == 2'h2 && chIdx < 5'h08) begin
            case (chIdx[2:0])
                3'h0: ch = decCh(hrs, 1'b1);
                3'h1: ch = decCh(hrs, 1'b0);
                3'h3: ch = decCh({1'b0, mins}, 1'b1);
                3'h4: ch = decCh({1'b0, mins}, 1'b0);
                3'h6: ch = decCh({1'b0, secs}, 1'b1);
                3'h7: ch = decCh({1'b0, secs}, 1'b0);
                default: ch = 8'h3A;
            endcase
        end else if (kind == 2'h2) begin
            if (chIdx > 5'h08 && chIdx < 5'h11) begin
                ch = hexCh(measVal[31 - 4 * (chIdx - 5'h09) -: 4]);
            end
        end else begin
            if (chIdx < 5'h04) begin
                ch = hexCh(countWide[15 - 4 * chIdx[1:0] -: 4]);
            end else if (chIdx > 5'h04 && chIdx < 5'h0D) begin
                ch = hexCh(measVal[31 - 4 * (chIdx - 5'h05) -: 4]);
            end else if (chIdx == 5'h0E) begin
                case (cmpDec)
                    2'h1: ch = 8'h48;
                    2'h2: ch = 8'h49;
                    2'h3: ch = 8'h4C;
                    default: ch = 8'h20;
                endcase
            end
        end
    end
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            chIdx <= 5'h00;
            chLast <= 5'h00;
            kind <= 2'h0;
            txValid <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    txValid <= 1'b0;
                    if (pendKind != 2'h0) begin
                        busy <= 1'b1;
                        kind <= pendKind;
                        chIdx <= 5'h00;
                        if (pendKind == 2'h3) begin
                            chLast <= (validCnt > 16'h0001) ? 5'h0E : 5'h05;
                        end else if (pendKind == 2'h2) begin
                            chLast <= 5'h12;
                        end else begin
                            chLast <= 5'h10;
                        end
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (txValid && txReady) begin
                        txValid <= 1'b0;
                        if (chIdx == chLast) begin
                            busy <= 1'b0;
                            state <= ST_IDLE;
                        end else begin
                            chIdx <= chIdx + 5'h01;
                        end
                    end else if (txReady) begin
                        txValid <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    mps_uart_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) uTx (
        .sys_clk(sys_clk),
        .rst(rst),
        .txValid(txValid),
        .txData(ch),
        .txReady(txReady),
        .txLine(txd)
    );
endmodule // mps_print_seq

// ===== tb/mps_print_seq_properties.sv
// Port-level assertions for the print sequencer
module mps_print_seq_props #(
    parameter BIT_CYCLES = 1041
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic triggerKey,
    input wire logic triggerInput_n,
    input wire logic statsSampleAdd,
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BC = BIT_CYCLES;
    int frameCyc;
    logic rd;
    assign rd = psel && penable && !pwrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****
    // Frame position, zero while idle
    // ****
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frameCyc <= 0;
        end else if (frameCyc == 10 * BC - 1) begin
            frameCyc <= 0;
        end else if (frameCyc != 0 || !txd) begin
            frameCyc <= frameCyc + 1;
        end
    end
    property p_idle_after_reset; $fell(rst) |-> txd; endproperty
    a_idle_after_reset: assert property (p_idle_after_reset)
        else $error("line not idle after reset");
    property p_start_bit; frameCyc > 0 && frameCyc < BC |-> !txd; endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("start bit too short");
    property p_stop_bit; frameCyc >= 9 * BC |-> txd; endproperty
    a_stop_bit: assert property (p_stop_bit)
        else $error("stop bit not high");
    // Mid-bit edges would corrupt a printer sampling late in the bit
    property p_bit_steady;
        frameCyc != 0 && frameCyc % BC != 0 |-> $stable(txd);
    endproperty
    a_bit_steady: assert property (p_bit_steady)
        else $error("line moved inside a bit");
    property p_count_range; rd && paddr == 12'h00C |-> prdata <= 32'h7530;
    endproperty
    a_count_range: assert property (p_count_range)
        else $error("sample count beyond limit");
    property p_intv_range; rd && paddr == 12'h004 |-> prdata <= 32'hE10;
    endproperty
    a_intv_range: assert property (p_intv_range)
        else $error("interval beyond limit");
    property p_hours_cap; rd && paddr == 12'h010 |-> prdata[18:12] <= 7'h63;
    endproperty
    a_hours_cap: assert property (p_hours_cap)
        else $error("hour field beyond limit");
    property p_sample_cause;
        statsSampleAdd |-> triggerKey || $past(!triggerInput_n, 2);
    endproperty
    a_sample_cause: assert property (p_sample_cause)
        else $error("sample added without trigger");
    c_frame: cover property (frameCyc == 1);
    c_sample_add: cover property (statsSampleAdd);
    c_count_read: cover property (rd && paddr == 12'h00C);
endmodule // mps_print_seq_props

// ===== tb/mps_printer_model.sv
// Behavioural serial printer collecting received text lines
module mps_printer_model #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic rxLine
);
    timeunit 1ns;
    timeprecision 1ns;
    string lines[$];
    string cur = "";
    int frameErr = 0;
    logic [7:0] rxByte;
    // ****
    // Receiver, no handshake to hold the sender off
    // ****
    initial begin
        forever begin
            @(negedge rxLine);
            repeat (BIT_CYCLES / 2) @(posedge sys_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge sys_clk);
                rxByte[i] = rxLine;
            end
            repeat (BIT_CYCLES) @(posedge sys_clk);
            if (rxLine !== 1'b1) frameErr++;
            if (rxByte == 8'h0A) begin
                lines.push_back(cur);
                cur = "";
            end else if (rxByte != 8'h0D) begin
                cur = {cur, string'(rxByte)};
            end
        end
    end
endmodule // mps_printer_model

// ===== tb/mps_print_seq_tb.sv
// Self-checking bench for the print sequencer
`include "mps_regs.vh"
module mps_print_seq_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic printKey = 1'b0;
    logic triggerKey = 1'b0;
    logic printPin_n = 1'b1;
    logic triggerInput_n = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, statsSampleAdd, txd;
    int errTotal = 0;
    int samplesChecked = 0;
    always #50 sys_clk = ~sys_clk;
    // Short second and bit time keep the run brief
    mps_print_seq #(.SEC_CYCLES(2000), .BIT_CYCLES(4)) DUT (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .printKey(printKey),
        .triggerKey(triggerKey), .printPin_n(printPin_n),
        .triggerInput_n(triggerInput_n), .statsSampleAdd(statsSampleAdd),
        .txd(txd));
    mps_printer_model #(.BIT_CYCLES(4)) printer (.sys_clk(sys_clk),
        .rxLine(txd));
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkS(string what, string exp, string got);
        samplesChecked++;
        if (got != exp) begin
            errTotal++;
            $display("[ERR] %s expected %s seen %s", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0, q);
    endtask
    task automatic pressPrint();
        printKey <= 1'b1;
        @(posedge sys_clk);
        printKey <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Waits for line n, then for the sender to go quiet
    task automatic waitLine(input int n, output string s);
        logic [31:0] q;
        int k = 0;
        while (printer.lines.size() <= n && k < 20000) begin
            @(posedge sys_clk);
            k++;
        end
        s = (k < 20000) ? printer.lines[n] : "none";
        do rd(`MPS_STAT_OFF, q); while (q[0] !== 1'b0 && k++ < 20000);
    endtask
    task automatic test_single();
        logic [31:0] q;
        string s;
        int n;
        rd(`MPS_CTRL_OFF, q);
        chk("ctrl reset", `MPS_CTRL_RESET, q);
        wr(12'h040, 32'hFFFF_FFFF);
        rd(12'h040, q);
        chk("unmapped", 32'h0, q);
        wr(`MPS_CTRL_OFF, 32'h1);
        wr(`MPS_MEAS_OFF, 32'h1234_ABCD);
        wr(`MPS_CMP_OFF, 32'h2);
        n = printer.lines.size();
        pressPrint();
        waitLine(n, s);
        chkS("key line", "0001 1234ABCD I", s);
        rd(`MPS_COUNT_OFF, q);
        chk("count", 32'h1, q);
        n = printer.lines.size();
        printPin_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        printPin_n <= 1'b1;
        waitLine(n, s);
        chkS("pin line", "0002 1234ABCD I", s);
        chk("one line", 32'(n + 1), 32'(printer.lines.size()));
    endtask
    task automatic test_trigger();
        string s;
        int n;
        logic seen = 1'b0;
        wr(`MPS_CTRL_OFF, 32'hD);
        n = printer.lines.size();
        triggerKey <= 1'b1;
        @(posedge sys_clk);
        chk("add on key", 32'h1, {31'h0, statsSampleAdd});
        triggerKey <= 1'b0;
        waitLine(n, s);
        chkS("key trigger line", "0003 1234ABCD I", s);
        triggerInput_n <= 1'b0;
        repeat (6) begin
            @(posedge sys_clk);
            seen = seen | statsSampleAdd;
        end
        triggerInput_n <= 1'b1;
        waitLine(n + 1, s);
        chk("add on pin", 32'h1, {31'h0, seen});
        chkS("pin trigger line", "0004 1234ABCD I", s);
    endtask
    task automatic test_interval();
        logic [31:0] q;
        string s;
        int n;
        wr(`MPS_CTRL_OFF, 32'h1);
        wr(`MPS_INTV_OFF, 32'hE11);
        rd(`MPS_INTV_OFF, q);
        chk("intv above max", 32'h0, q);
        wr(`MPS_INTV_OFF, 32'hE10);
        rd(`MPS_INTV_OFF, q);
        chk("intv at max", 32'hE10, q);
        wr(`MPS_INTV_OFF, 32'h1);
        n = printer.lines.size();
        pressPrint();
        rd(`MPS_STAT_OFF, q);
        chk("run on", 32'h1, {31'h0, q[1]});
        waitLine(n, s);
        chkS("first stamp", "00:00:01 1234ABCD", s);
        waitLine(n + 1, s);
        chkS("second stamp", "00:00:02 1234ABCD", s);
        rd(`MPS_ELAP_OFF, q);
        chk("elapsed", 32'h0000_0002, q);
        pressPrint();
        rd(`MPS_STAT_OFF, q);
        chk("run off", 32'h0, {31'h0, q[1]});
        pressPrint();
        wr(`MPS_CTRL_OFF, 32'h2);
        rd(`MPS_STAT_OFF, q);
        chk("run off display", 32'h0, {31'h0, q[1]});
    endtask
    task automatic test_stats();
        string s;
        int n;
        string want[3] = '{"0000", "0001", "0002 000000AB"};
        for (int k = 0; k < 3; k++) begin
            wr(`MPS_STATS_OFF, {16'h00AB, 16'(k)});
            n = printer.lines.size();
            pressPrint();
            waitLine(n, s);
            chkS("stats line", want[k], s);
        end
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        test_single();
        test_trigger();
        test_interval();
        test_stats();
        chk("framing", 32'h0, 32'(printer.frameErr));
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        errTotal++;
        end_of_test();
    end
endmodule // mps_print_seq_tb
bind mps_print_seq mps_print_seq_props #(.BIT_CYCLES(BIT_CYCLES)) props (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .triggerKey(triggerKey), .triggerInput_n(triggerInput_n),
    .statsSampleAdd(statsSampleAdd), .txd(txd));
